// ---- pkg/rif_map.svh ----
`ifndef RIF_MAP_SVH
`define RIF_MAP_SVH

`define RIF_ADDR_PIN_MAP_A      8'h25
`define RIF_ADDR_PIN_MAP_B      8'h26
`define RIF_ADDR_IRQ_STATUS_A   8'h27
`define RIF_ADDR_IRQ_STATUS_B   8'h28
`define RIF_ADDR_LEVEL_TRIGGER  8'h29
`define RIF_ADDR_START_WAIT     8'h2a
`define RIF_ADDR_POST_WAIT      8'h2b

`define RIF_PIN_MAP_RESET       8'h00
`define RIF_SEL_RESET           2'h0
`define RIF_TRIGGER_RESET       8'he4
`define RIF_WAIT_RESET          8'h00
`define RIF_REFERENCE_CLOCK_OUTPUT_PIN_RESET        3'h7

`define RIF_REFERENCE_CLOCK_OUTPUT_PIN_DIV1         3'h0
`define RIF_REFERENCE_CLOCK_OUTPUT_PIN_RC           3'h6

`define RIF_BUF_FULL_COUNT      7'h42
`define RIF_TIMEOUT_SHIFT       4

`define RIF_RSSI_BIT            3
`define RIF_SYNC_BIT            0
`define RIF_OVERRUN_BIT         4

`endif

// ---- pkg/rif_pkg.sv ----
package rif_pkg;

   typedef enum logic [2:0] {
      RIF_SLEEP,
      RIF_STANDBY,
      RIF_SYNTH,
      RIF_RX,
      RIF_TX
   } rif_mode_type;

endpackage : rif_pkg

// ---- core/rif_bit_timer.sv ----
`include "rif_map.svh"

module rif_bit_timer #(
   parameter int DIV_W = 16,
   parameter int LIM_W = 8
) (
   input  wire logic             core_clk,
   input  wire logic             rstn,
   input  wire logic             restart,
   input  wire logic             run,
   input  wire logic [LIM_W-1:0] limit,
   input  wire logic [DIV_W-1:0] bitCycles,
   output logic                  expire
);
   localparam int CNT_W = LIM_W + `RIF_TIMEOUT_SHIFT;

   logic [DIV_W-1:0] cycCount;
   logic [CNT_W-1:0] bitCount;
   logic             armed;

   // Limit counts units of 16 bit periods
   wire [CNT_W-1:0] target  = {limit, {`RIF_TIMEOUT_SHIFT{1'b0}}};
   wire [DIV_W-1:0] nextCyc = cycCount + 1'b1;
   wire             active  = run && armed;
   // A bit period of zero cycles behaves as one cycle
   wire             bitTick = active && (nextCyc >= bitCycles);
   wire             lastBit = bitTick && (bitCount == target - 1'b1);

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         cycCount <= '0;
         bitCount <= '0;
         armed    <= 1'b0;
         expire   <= 1'b0;
      end else if (restart) begin
         cycCount <= '0;
         bitCount <= '0;
         armed    <= (limit != '0);
         expire   <= 1'b0;
      end else begin
         expire <= lastBit;
         if (lastBit) begin
            armed <= 1'b0;
         end
         if (bitTick) begin
            cycCount <= '0;
            bitCount <= bitCount + 1'b1;
         end else if (active) begin
            cycCount <= nextCyc;
         end
      end
   end

endmodule : rif_bit_timer

// ---- core/rif_clk_div.sv ----
module rif_clk_div #(
   parameter int CNT_W = 5
) (
   input  wire logic       core_clk,
   input  wire logic       rstn,
   input  wire logic [2:0] sel,
   output logic            divClk
);
   logic [CNT_W-1:0] count;

   wire [CNT_W-1:0] nextCount = count + 1'b1;
   // Codes 1 to CNT_W pick a counter bit, all others hold low
   wire             inRange   = (sel != 3'h0) && ({29'h0, sel} <= CNT_W);
   wire             divBit    = inRange && nextCount[sel - 3'h1];

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         count  <= '0;
         divClk <= 1'b0;
      end else begin
         count  <= nextCount;
         divClk <= divBit;
      end
   end

endmodule : rif_clk_div

// ---- core/rif_flags.sv ----
// Behaviour
// R1 - Six 2-bit pin selectors, reset zero
// R2 - Divider select drives reference clock pin
// R3 - Mode ready set per mode, cleared on change
// R4 - Receive settled after receive chain done
// R5 - Transmit settled after amplifier ramp-up
// R6 - Lock flag follows PLL in active modes
// R7 - Level flag set above trigger, write clears
// R8 - Timeout set by either timer, clears
// R9 - Intermediate flag tracks sequencer state
// R10 - Frame start flag on sync and address
// R11 - Full flag exactly at 66 bytes
// R12 - Has-data flag when one byte held
// R13 - Above-level flag strictly greater than setting
// R14 - Overrun flag; write one flushes buffer
// R15 - Frame sent flag set in transmit
// R16 - Frame complete after last byte, checksum
// R17 - Checksum passed flag, cleared when emptied
// R18 - Trigger level register, default 0xe4
// R19 - Start timer: limit times 16 bits
// R20 - Post-level timer: limit times 16 bits
// R21 - Reading is magnitude in half-dB steps
// R22 - Checksum fail flushes and restarts reception
// R23 - Timers tick per bit, restart on start
// R24 - Unused bits read zero, writes ignored
//
// Design decision made here: the strobed register port.
`include "rif_map.svh"

module rif_flags #(
   parameter int DIV_W   = 16,
   parameter int LEVEL_W = 7
) (
   input  wire logic                core_clk,
   input  wire logic                rstn,
   input  wire logic [7:0]          regAddr,
   input  wire logic [7:0]          regWrData,
   input  wire logic                regWrite,
   input  wire logic                regRead,
   output logic [7:0]               regRdData,
   input  wire rif_pkg::rif_mode_type opMode,
   input  wire logic                oscRunning,
   input  wire logic                pllLocked,
   input  wire logic                rssiSampling,
   input  wire logic                paRampDone,
   input  wire logic                rxChainDone,
   input  wire logic                intermediateMode,
   input  wire logic [7:0]          signalStrengthReading,
   input  wire logic                syncAddressFound,
   input  wire logic                packetMode,
   input  wire logic [6:0]          bufferCount,
   input  wire logic [LEVEL_W-1:0]  bufferLevelSetting,
   input  wire logic                bufferOverrun,
   input  wire logic                frameSentDone,
   input  wire logic                lastByteReceived,
   input  wire logic                checksumEnable,
   input  wire logic                checksumGood,
   input  wire logic                keepOnChecksumFail,
   input  wire logic [DIV_W-1:0]    bitPeriodCycles,
   input  wire logic                rcOscClk,
   output logic [1:0]               pin0FunctionSel,
   output logic [1:0]               pin1FunctionSel,
   output logic [1:0]               pin2FunctionSel,
   output logic [1:0]               pin3FunctionSel,
   output logic [1:0]               pin4FunctionSel,
   output logic [1:0]               pin5FunctionSel,
   output logic [7:0]               irqStatusA,
   output logic [7:0]               irqStatusB,
   output logic                     bufferFlush,
   output logic                     rxRestart,
   output logic                     rcOscEnable,
   output logic                     referenceClockOutputPin
);
   // Flags and configuration
   logic       requestedStateReached;
   logic       receivePathSettled;
   logic       transmitPathSettled;
   logic       synthesizerLocked;
   logic       signalStrengthOverLevel;
   logic       timeoutFlag;
   logic       intermediateStateActive;
   logic       frameStartMatched;
   logic       bufferFullFlag;
   logic       bufferHasData;
   logic       bufferAboveLevel;
   logic       bufferOverflowFlag;
   logic       frameSentFlag;
   logic       receivedFrameComplete;
   logic       checksumPassed;
   logic [7:0] signalStrengthTriggerLevel;
   logic [7:0] receiveStartWaitLimit;
   logic [7:0] postLevelWaitLimit;
   logic [2:0] clockOutputDividerSel;
   logic       divClk;
   logic       startExpire;
   logic       postExpire;
   rif_pkg::rif_mode_type prevMode;
   logic       prevHasData;

   // Mode decode
   wire modeChange = (opMode != prevMode);
   wire inRx       = (opMode == rif_pkg::RIF_RX);
   wire inTx       = (opMode == rif_pkg::RIF_TX);
   wire inSleep    = (opMode == rif_pkg::RIF_SLEEP);
   wire inSynth    = (opMode == rif_pkg::RIF_SYNTH);
   wire leaveRx    = (prevMode == rif_pkg::RIF_RX) && !inRx;
   wire leaveTx    = (prevMode == rif_pkg::RIF_TX) && !inTx;
   wire enterRx    = inRx && (prevMode != rif_pkg::RIF_RX);

   // Register bus decode
   wire selMapA    = (regAddr == `RIF_ADDR_PIN_MAP_A);
   wire selMapB    = (regAddr == `RIF_ADDR_PIN_MAP_B);
   wire selStatA   = (regAddr == `RIF_ADDR_IRQ_STATUS_A);
   wire selStatB   = (regAddr == `RIF_ADDR_IRQ_STATUS_B);
   wire selTrig    = (regAddr == `RIF_ADDR_LEVEL_TRIGGER);
   wire selStart   = (regAddr == `RIF_ADDR_START_WAIT);
   wire selPost    = (regAddr == `RIF_ADDR_POST_WAIT);
   wire wrMapA     = regWrite && selMapA;
   wire wrMapB     = regWrite && selMapB;
   wire wrTrig     = regWrite && selTrig;
   wire wrStart    = regWrite && selStart;
   wire wrPost     = regWrite && selPost;

   // Write-one clears; frame start only in continuous mode
   wire clrLevel   = regWrite && selStatA && regWrData[`RIF_RSSI_BIT];  // R7
   wire clrMatch   = regWrite && selStatA && regWrData[`RIF_SYNC_BIT]
                     && !packetMode;  // R10
   wire clrOverrun = regWrite && selStatB && regWrData[`RIF_OVERRUN_BIT];  // R14

   // Readiness per requested mode
   logic modeIsReady;
   always_comb begin
      unique case (opMode)
         rif_pkg::RIF_SLEEP:   modeIsReady = 1'b1;
         rif_pkg::RIF_STANDBY: modeIsReady = oscRunning;
         rif_pkg::RIF_SYNTH:   modeIsReady = pllLocked;
         rif_pkg::RIF_RX:      modeIsReady = rssiSampling;
         rif_pkg::RIF_TX:      modeIsReady = paRampDone;
         default:              modeIsReady = 1'b0;
      endcase
   end

   // Reading is a magnitude, so larger value means weaker signal
   wire levelAbove    = inRx && (signalStrengthReading > signalStrengthTriggerLevel);  // R21
   wire bufferEmptied = prevHasData && (bufferCount == '0);
   wire frameDone     = inRx && lastByteReceived;
   wire checksumFail  = frameDone && checksumEnable && !checksumGood;
   wire frameAccept   = frameDone && (!checksumFail || keepOnChecksumFail);  // R16
   wire failFlush     = checksumFail && !keepOnChecksumFail;  // R22
   wire levelRise     = levelAbove && !signalStrengthOverLevel;
   wire lockActive    = (inSynth || inRx || inTx) && pllLocked;  // R6

   // Set wins over clear, except a mode change clears the ready flag
   wire next_stateReached = modeChange ? 1'b0 : (modeIsReady || requestedStateReached);  // R3
   wire next_rxSettled = (inRx && rxChainDone) || (receivePathSettled && !leaveRx);  // R4
   wire next_txSettled = (inTx && paRampDone) || (transmitPathSettled && !leaveTx);  // R5
   wire next_overLevel = levelAbove
                         || (signalStrengthOverLevel && !leaveRx && !clrLevel);  // R7
   wire next_timeout   = startExpire || postExpire
                         || (timeoutFlag && !leaveRx && !bufferEmptied);  // R8
   wire next_match     = (inRx && syncAddressFound)
                         || (frameStartMatched && !leaveRx && !bufferEmptied && !clrMatch);  // R10
   wire next_overflow  = (bufferOverrun && !inSleep)
                         || (bufferOverflowFlag && !clrOverrun);  // R14
   wire next_sent      = (inTx && frameSentDone) || (frameSentFlag && !leaveTx);  // R15
   wire next_complete  = frameAccept || (receivedFrameComplete && !bufferEmptied);  // R16
   wire next_checksum  = (frameDone && checksumEnable && checksumGood)
                         || (checksumPassed && !bufferEmptied);  // R17

   // Unused bits and addresses read zero
   wire [7:0] mapBRead = {pin4FunctionSel, pin5FunctionSel, 1'b0,
                          clockOutputDividerSel};  // R24
   wire [7:0] next_rdData =
      selMapA  ? {pin0FunctionSel, pin1FunctionSel, pin2FunctionSel, pin3FunctionSel} :
      selMapB  ? mapBRead :
      selStatA ? irqStatusA :
      selStatB ? irqStatusB :
      selTrig  ? signalStrengthTriggerLevel :
      selStart ? receiveStartWaitLimit :
      selPost  ? postLevelWaitLimit : 8'h00;  // R24

   // Receive timeout timers
   rif_bit_timer #(
      .DIV_W (DIV_W),
      .LIM_W (8)
   ) u_start_timer (
      .core_clk  (core_clk),
      .rstn      (rstn),
      .restart   (enterRx),
      .run       (inRx && !signalStrengthOverLevel),
      .limit     (receiveStartWaitLimit),
      .bitCycles (bitPeriodCycles),
      .expire    (startExpire)
   );  // R19 R23

   rif_bit_timer #(
      .DIV_W (DIV_W),
      .LIM_W (8)
   ) u_post_timer (
      .core_clk  (core_clk),
      .rstn      (rstn),
      .restart   (levelRise),
      .run       (inRx && !receivedFrameComplete),
      .limit     (postLevelWaitLimit),
      .bitCycles (bitPeriodCycles),
      .expire    (postExpire)
   );  // R20 R23

   rif_clk_div #(
      .CNT_W (5)
   ) u_clk_div (
      .core_clk (core_clk),
      .rstn     (rstn),
      .sel      (clockOutputDividerSel),
      .divClk   (divClk)
   );

   // Divide-by-one and RC cannot come from a flop; the mux may glitch on a code change
   assign referenceClockOutputPin =
      (clockOutputDividerSel == `RIF_REFERENCE_CLOCK_OUTPUT_PIN_DIV1) ? core_clk :
      rcOscEnable ? rcOscClk : divClk;  // R2

   // Configuration registers
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         pin0FunctionSel <= `RIF_SEL_RESET;
         pin1FunctionSel <= `RIF_SEL_RESET;
         pin2FunctionSel <= `RIF_SEL_RESET;
         pin3FunctionSel <= `RIF_SEL_RESET;
      end else if (wrMapA) begin
         {pin0FunctionSel, pin1FunctionSel, pin2FunctionSel, pin3FunctionSel} <= regWrData;  // R1
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         pin4FunctionSel       <= `RIF_SEL_RESET;
         pin5FunctionSel       <= `RIF_SEL_RESET;
         clockOutputDividerSel <= `RIF_REFERENCE_CLOCK_OUTPUT_PIN_RESET;
         rcOscEnable           <= 1'b0;
      end else begin
         if (wrMapB) begin
            {pin4FunctionSel, pin5FunctionSel} <= regWrData[7:4];  // R1
            clockOutputDividerSel             <= regWrData[2:0];  // R24
         end
         rcOscEnable <= (clockOutputDividerSel == `RIF_REFERENCE_CLOCK_OUTPUT_PIN_RC);  // R2
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         signalStrengthTriggerLevel <= `RIF_TRIGGER_RESET;
         receiveStartWaitLimit      <= `RIF_WAIT_RESET;
         postLevelWaitLimit         <= `RIF_WAIT_RESET;
      end else begin
         if (wrTrig) begin
            signalStrengthTriggerLevel <= regWrData;  // R18
         end
         if (wrStart) begin
            receiveStartWaitLimit <= regWrData;  // R19
         end
         if (wrPost) begin
            postLevelWaitLimit <= regWrData;  // R20
         end
      end
   end

   // Mode tracking and read data
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         prevMode    <= rif_pkg::RIF_SLEEP;
         prevHasData <= 1'b0;
         regRdData   <= 8'h00;
      end else begin
         prevMode    <= opMode;
         prevHasData <= (bufferCount != '0);
         regRdData   <= regRead ? next_rdData : 8'h00;
      end
   end

   // Status flags of the first group
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         requestedStateReached   <= 1'b1;
         receivePathSettled      <= 1'b0;
         transmitPathSettled     <= 1'b0;
         synthesizerLocked       <= 1'b0;
         signalStrengthOverLevel <= 1'b0;
         timeoutFlag             <= 1'b0;
         intermediateStateActive <= 1'b0;
         frameStartMatched       <= 1'b0;
      end else begin
         requestedStateReached   <= next_stateReached;  // R3
         receivePathSettled      <= next_rxSettled;  // R4
         transmitPathSettled     <= next_txSettled;  // R5
         synthesizerLocked       <= lockActive;  // R6
         signalStrengthOverLevel <= next_overLevel;  // R7
         timeoutFlag             <= next_timeout;  // R8
         intermediateStateActive <= intermediateMode;  // R9
         frameStartMatched       <= next_match;  // R10
      end
   end

   // Buffer and frame flags
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         bufferFullFlag        <= 1'b0;
         bufferHasData         <= 1'b0;
         bufferAboveLevel      <= 1'b0;
         bufferOverflowFlag    <= 1'b0;
         frameSentFlag         <= 1'b0;
         receivedFrameComplete <= 1'b0;
         checksumPassed        <= 1'b0;
      end else begin
         bufferFullFlag        <= (bufferCount == `RIF_BUF_FULL_COUNT);  // R11
         bufferHasData         <= (bufferCount != '0);  // R12
         bufferAboveLevel      <= ({{LEVEL_W{1'b0}}, bufferCount}
                                   > {7'h00, bufferLevelSetting});  // R13
         bufferOverflowFlag    <= next_overflow;  // R14
         frameSentFlag         <= next_sent;  // R15
         receivedFrameComplete <= next_complete;  // R16
         checksumPassed        <= next_checksum;  // R17
      end
   end

   // Flush and restart strobes
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         bufferFlush <= 1'b0;
         rxRestart   <= 1'b0;
      end else begin
         bufferFlush <= clrOverrun || failFlush;  // R14 R22
         rxRestart   <= failFlush;  // R22
      end
   end

   assign irqStatusA = {requestedStateReached, receivePathSettled, transmitPathSettled,
                        synthesizerLocked, signalStrengthOverLevel, timeoutFlag,
                        intermediateStateActive, frameStartMatched};
   assign irqStatusB = {bufferFullFlag, bufferHasData, bufferAboveLevel,
                        bufferOverflowFlag, frameSentFlag, receivedFrameComplete,
                        checksumPassed, 1'b0};

endmodule : rif_flags

// ---- tb/rif_flags_checker.sv ----
module rif_flags_checker #(
   parameter int LEVEL_W = 7
) (
   input wire logic                  core_clk,
   input wire logic                  rstn,
   input wire logic [7:0]            regAddr,
   input wire logic [7:0]            regWrData,
   input wire logic                  regWrite,
   input wire logic                  regRead,
   input wire logic [7:0]            regRdData,
   input wire rif_pkg::rif_mode_type opMode,
   input wire logic                  pllLocked,
   input wire logic [6:0]            bufferCount,
   input wire logic [LEVEL_W-1:0]    bufferLevelSetting,
   input wire logic                  bufferOverrun,
   input wire logic [7:0]            irqStatusA,
   input wire logic [7:0]            irqStatusB,
   input wire logic                  bufferFlush
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   sequence leave_rx;
      opMode == rif_pkg::RIF_RX ##1 opMode != rif_pkg::RIF_RX;
   endsequence
   sequence leave_tx;
      opMode == rif_pkg::RIF_TX ##1 opMode != rif_pkg::RIF_TX;
   endsequence
   sequence clear_overrun;
      regWrite && regAddr == 8'h28 && regWrData[4];
   endsequence

   unmapped_read_a: assert property (
      regRead && (regAddr < 8'h25 || regAddr > 8'h2b) |=> regRdData == 8'h00)
      else $error("bad unmapped read");
   full_flag_a: assert property (
      1'b1 |=> irqStatusB[7] == ($past(bufferCount) == 7'h42))
      else $error("full flag wrong");
   has_data_a: assert property (
      1'b1 |=> irqStatusB[6] == ($past(bufferCount) != 7'h00))
      else $error("has-data flag wrong");
   above_level_a: assert property (
      1'b1 |=> irqStatusB[5] == ($past(bufferCount) > $past(bufferLevelSetting)))
      else $error("above-level flag wrong");
   lock_follow_a: assert property (
      opMode inside {rif_pkg::RIF_SYNTH, rif_pkg::RIF_RX, rif_pkg::RIF_TX}
      |=> irqStatusA[4] == $past(pllLocked))
      else $error("bad lock flag");
   rx_leave_a: assert property (
      leave_rx |=> !irqStatusA[6] && !irqStatusA[3] && !irqStatusA[0])
      else $error("receive flags kept");
   tx_leave_a: assert property (
      leave_tx |=> !irqStatusA[5] && !irqStatusB[3])
      else $error("transmit flags kept");
   overrun_flush_a: assert property (
      clear_overrun |=> bufferFlush ##1 !bufferFlush)
      else $error("flush pulse wrong");
   sleep_overrun_a: assert property (
      opMode == rif_pkg::RIF_SLEEP && bufferOverrun && !irqStatusB[4] |=> !irqStatusB[4])
      else $error("overrun flagged in sleep");
endmodule : rif_flags_checker

bind rif_flags rif_flags_checker #(.LEVEL_W(LEVEL_W)) rif_flags_checker_inst (.*);

// ---- tb/rif_host_model.sv ----
module rif_host_model (
   input wire logic  core_clk,
   input wire logic  rstn,
   input wire logic  pinLevel,
   input wire logic  clearCount,
   output logic [7:0] riseCount
);
   timeunit 1ns;
   timeprecision 100ps;
   logic lastLevel;

   // Host samples the pin on the core clock
   always_ff @(posedge core_clk) begin
      lastLevel <= pinLevel;
      if (!rstn || clearCount) begin
         riseCount <= 8'h00;
      end else if (pinLevel && !lastLevel) begin
         riseCount <= riseCount + 8'h01;
      end
   end
endmodule : rif_host_model

// ---- tb/tb_rif_flags.sv ----
module tb_rif_flags;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk = '0, rstn = '0, regWrite = '0, regRead = '0, rcOscClk = '0;
   logic [7:0] regAddr = '0, regWrData = '0, signalStrengthReading = '0;
   logic oscRunning = '0, pllLocked = '0, rssiSampling = '0, paRampDone = '0;
   logic rxChainDone = '0, intermediateMode = '0, syncAddressFound = '0, packetMode = 1'h1;
   logic bufferOverrun = '0, frameSentDone = '0, lastByteReceived = '0, checksumEnable = '0;
   logic checksumGood = '0, keepOnChecksumFail = '0, clearCount = '0;
   logic [6:0] bufferCount = '0, bufferLevelSetting = 7'h10;
   logic [15:0] bitPeriodCycles = 16'h0001;
   rif_pkg::rif_mode_type opMode = rif_pkg::RIF_SLEEP;
   logic [7:0] regRdData, irqStatusA, irqStatusB, riseCount;
   logic [1:0] pin0FunctionSel, pin1FunctionSel, pin2FunctionSel;
   logic [1:0] pin3FunctionSel, pin4FunctionSel, pin5FunctionSel;
   logic bufferFlush, rxRestart, rcOscEnable, referenceClockOutputPin;
   int err_count = 0, compares = 0, cycles = 0;

   rif_flags #(.DIV_W(16), .LEVEL_W(7)) rif_flags_inst (.*);
   rif_host_model rif_host_model_inst (.pinLevel(referenceClockOutputPin), .*);

   initial begin
      forever #2.5 core_clk = ~core_clk;
   end

   // RC oscillator stand-in, 8 cycles
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles % 4 == 0) rcOscClk <= ~rcOscClk;
      if (cycles == 5000) begin
         err_count++;
         give_verdict();
      end
   end

   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   task automatic nx;
      @(posedge core_clk);
   endtask : nx

   task automatic go(input rif_pkg::rif_mode_type m);
      nx();
      opMode <= m;
   endtask : go

   task automatic st(input int n);
      repeat (n) nx();
      #1;
   endtask : st

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      nx();
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      nx();
      regWrite <= 1'b0;
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      nx();
      regRead <= 1'b1;
      regAddr <= a;
      nx();
      regRead <= 1'b0;
      #1;
      chk(regRdData, e);
   endtask : rdc

   task automatic t_reset;
      logic [63:0] ad = 64'h25262728292a2b3c;
      logic [63:0] rv = 64'h00078000e4000000;
      for (int i = 0; i < 8; i++) begin
         rdc(ad[63-8*i -: 8], rv[63-8*i -: 8]);
      end
   endtask : t_reset

   task automatic t_regs;
      wr(8'h25, 8'h1b);
      st(1);
      chk({pin0FunctionSel, pin1FunctionSel, pin2FunctionSel, pin3FunctionSel}, 8'h1b);
      wr(8'h26, 8'hbf);
      rdc(8'h26, 8'hb7);
      chk({pin4FunctionSel, pin5FunctionSel}, 4'hb);
      wr(8'h3c, 8'hff);
      rdc(8'h3c, 8'h00);
      wr(8'h29, 8'h40);
      rdc(8'h29, 8'h40);
      wr(8'h28, 8'hef);
      rdc(8'h28, 8'h00);
      wr(8'h27, 8'hff);
      rdc(8'h27, 8'h80);
   endtask : t_regs

   task automatic t_reference_clock_output_pin;
      int e;
      for (int k = 1; k < 8; k++) begin
         wr(8'h26, {5'h00, k[2:0]});
         st(8);
         nx();
         clearCount <= 1'b1;
         nx();
         clearCount <= 1'b0;
         st(64);
         e = (k < 6) ? (64 >> k) : ((k == 6) ? 8 : 0);
         chk(riseCount, e[15:0]);
         chk(rcOscEnable, (k == 6));
      end
   endtask : t_reference_clock_output_pin

   task automatic t_modes;
      go(rif_pkg::RIF_STANDBY);
      st(2);
      chk(irqStatusA[7], 1'b0);
      nx();
      oscRunning <= 1'b1;
      intermediateMode <= 1'b1;
      st(2);
      chk({irqStatusA[7], irqStatusA[1]}, 2'h3);
      go(rif_pkg::RIF_TX);
      intermediateMode <= 1'b0;
      pllLocked <= 1'b1;
      st(2);
      chk({irqStatusA[7:4], irqStatusA[1]}, 5'h02);
      nx();
      paRampDone <= 1'b1;
      frameSentDone <= 1'b1;
      nx();
      frameSentDone <= 1'b0;
      st(1);
      chk({irqStatusA[7:4], irqStatusB[3]}, 5'h17);
      go(rif_pkg::RIF_SYNTH);
      pllLocked <= 1'b0;
      st(2);
      chk({irqStatusA[7:4], irqStatusB[3]}, 5'h00);
      nx();
      pllLocked <= 1'b1;
      st(2);
      chk(irqStatusA[7:4], 4'h9);
   endtask : t_modes

   task automatic t_rx;
      go(rif_pkg::RIF_RX);
      rssiSampling <= 1'b1;
      rxChainDone <= 1'b1;
      signalStrengthReading <= 8'h40;
      st(2);
      chk({irqStatusA[7:6], irqStatusA[3]}, 3'h6);
      nx();
      signalStrengthReading <= 8'h41;
      st(2);
      chk(irqStatusA[3], 1'b1);
      nx();
      signalStrengthReading <= 8'h00;
      wr(8'h27, 8'h08);
      st(1);
      chk(irqStatusA[3], 1'b0);
      nx();
      syncAddressFound <= 1'b1;
      nx();
      syncAddressFound <= 1'b0;
      wr(8'h27, 8'h01);
      st(1);
      chk(irqStatusA[0], 1'b1);
      nx();
      packetMode <= 1'b0;
      wr(8'h27, 8'h01);
      st(1);
      chk(irqStatusA[0], 1'b0);
      nx();
      packetMode <= 1'b1;
      syncAddressFound <= 1'b1;
      signalStrengthReading <= 8'h41;
      nx();
      syncAddressFound <= 1'b0;
      st(1);
      chk({irqStatusA[3], irqStatusA[0]}, 2'h3);
      go(rif_pkg::RIF_STANDBY);
      signalStrengthReading <= 8'h00;
      st(2);
      chk({irqStatusA[6], irqStatusA[3], irqStatusA[0]}, 3'h0);
   endtask : t_rx

   task automatic t_timeout;
      wr(8'h2a, 8'h02);
      go(rif_pkg::RIF_RX);
      st(28);
      chk(irqStatusA[2], 1'b0);
      st(10);
      chk(irqStatusA[2], 1'b1);
      nx();
      bufferCount <= 7'h03;
      nx();
      bufferCount <= 7'h00;
      st(2);
      chk(irqStatusA[2], 1'b0);
      go(rif_pkg::RIF_STANDBY);
      wr(8'h2a, 8'h00);
      wr(8'h2b, 8'h01);
      go(rif_pkg::RIF_RX);
      signalStrengthReading <= 8'h41;
      st(14);
      chk(irqStatusA[2], 1'b0);
      st(10);
      chk(irqStatusA[2], 1'b1);
      go(rif_pkg::RIF_STANDBY);
      signalStrengthReading <= 8'h00;
      st(2);
      chk(irqStatusA[2], 1'b0);
   endtask : t_timeout

   task automatic t_buffer;
      logic [41:0] cv = {7'h01, 7'h10, 7'h11, 7'h41, 7'h42, 7'h00};
      logic [17:0] ev = {3'h2, 3'h2, 3'h3, 3'h3, 3'h7, 3'h0};
      for (int i = 0; i < 6; i++) begin
         nx();
         bufferCount <= cv[41-7*i -: 7];
         st(2);
         chk(irqStatusB[7:5], ev[17-3*i -: 3]);
      end
      go(rif_pkg::RIF_SLEEP);
      bufferOverrun <= 1'b1;
      nx();
      bufferOverrun <= 1'b0;
      st(1);
      chk(irqStatusB[4], 1'b0);
      go(rif_pkg::RIF_STANDBY);
      bufferOverrun <= 1'b1;
      nx();
      bufferOverrun <= 1'b0;
      st(1);
      chk(irqStatusB[4], 1'b1);
      wr(8'h28, 8'h10);
      #1;
      chk(bufferFlush, 1'b1);
      st(1);
      chk({bufferFlush, irqStatusB[4]}, 2'h0);
   endtask : t_buffer

   task automatic t_checksum;
      go(rif_pkg::RIF_RX);
      checksumEnable <= 1'b1;
      bufferCount <= 7'h05;
      lastByteReceived <= 1'b1;
      nx();
      lastByteReceived <= 1'b0;
      #1;
      chk({bufferFlush, rxRestart}, 2'h3);
      st(1);
      chk(irqStatusB[2:1], 2'h0);
      nx();
      keepOnChecksumFail <= 1'b1;
      lastByteReceived <= 1'b1;
      nx();
      lastByteReceived <= 1'b0;
      st(1);
      chk(irqStatusB[2:1], 2'h2);
      nx();
      checksumGood <= 1'b1;
      lastByteReceived <= 1'b1;
      nx();
      lastByteReceived <= 1'b0;
      st(1);
      chk(irqStatusB[2:1], 2'h3);
      nx();
      bufferCount <= 7'h00;
      st(2);
      chk(irqStatusB[2:1], 2'h0);
   endtask : t_checksum

   initial begin
      repeat (10) @(posedge core_clk);
      rstn <= 1'b1;
      t_reset();
      t_regs();
      t_reference_clock_output_pin();
      t_modes();
      t_rx();
      t_timeout();
      t_buffer();
      t_checksum();
      give_verdict();
   end
endmodule : tb_rif_flags
